// [src/adcctl_regs.sv]
/*
  Converter control registers behind an Avalon-MM slave.
  Assumes a master that holds requests until waitrequest is low; the
  analog core reports completion through conv_done, or the internal
  cycle count ends the conversion when conv_done is never seen.
*/
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "adcctl_defs.svh"

module adcctl_regs #(
  parameter int CONV_CYCLES = `ADCCTL_CONV_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [11:0]          conv_result,
  input  wire logic                 conv_done,
  input  wire logic                 low_voltage_reset_detect,
  output adcctl_pkg::adcctl_analog_t analog_ctrl,
  output adcctl_pkg::adcctl_pins_t  pin_ctrl,
  output logic                      conv_clk_en,
  output logic                      conv_start,
  output logic                      conv_irq_pulse
);
  import adcctl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]    first_reg;
  logic [7:0]    first_next;
  logic [7:0]    second_reg;
  logic [7:0]    second_next;
  logic [3:0]    pins_reg;
  logic [3:0]    pins_next;
  logic          ack_reg;
  logic          ack_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  adcctl_state_t state_reg;
  adcctl_state_t state_next;
  logic          busy_reg;
  logic          busy_next;
  logic [15:0]   cyc_reg;
  logic [15:0]   cyc_next;
  logic          start_pulse_reg;
  logic          start_pulse_next;
  logic          done_pulse_reg;
  logic          done_pulse_next;
  logic [11:0]   result_reg;
  logic [11:0]   result_next;

  logic          req;
  logic          wr_hit;
  logic [7:0]    wbyte;
  logic          start_bit;
  logic [31:0]   result_word;
  logic          conv_end;

  assign req   = avs_read | avs_write;
  assign wr_hit = avs_write & ~ack_reg & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign start_bit = first_reg[`ADCCTL_B_START];

  // one wait cycle then an answer, every access
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  // ----------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------
  adcctl_clkdiv u_clkdiv (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .div_sel     (second_reg[2:0]),
    .conv_clk_en (conv_clk_en)
  );

  // ----------------------------------------------------------------
  // result alignment
  // ----------------------------------------------------------------
  // left or right aligned, high byte above low byte
  always_comb begin
    if (first_reg[`ADCCTL_B_ALIGN]) begin
      result_word = {20'h00000, result_reg};
    end else begin
      result_word = {16'h0000, result_reg, 4'h0};
    end
  end

  // ----------------------------------------------------------------
  // bus and registers
  // ----------------------------------------------------------------
  always_comb begin
    first_next  = first_reg;
    second_next = second_reg;
    pins_next   = pins_reg;
    ack_next    = req & ~ack_reg;
    rdata_next  = rdata_reg;
    if (wr_hit) begin
      if (avs_address == `ADCCTL_OFS_CTRL_FIRST) begin
        // busy bit kept, not writable; holes masked
        first_next = (wbyte & `ADCCTL_MASK_FIRST & 8'hBF)
                   | (first_reg & 8'h40);
      end else if (avs_address == `ADCCTL_OFS_CTRL_SECOND) begin
        // bits 5 and 3 never stored
        second_next = wbyte & `ADCCTL_MASK_SECOND;
      end else if (avs_address == `ADCCTL_OFS_PIN_ENABLE) begin
        pins_next = wbyte[3:0];
      end
    end
    first_next[`ADCCTL_B_BUSY] = busy_next;
    if (avs_read & ~ack_reg) begin
      if (avs_address == `ADCCTL_OFS_CTRL_FIRST) begin
        rdata_next = {24'h000000, first_reg};
      end else if (avs_address == `ADCCTL_OFS_CTRL_SECOND) begin
        rdata_next = {24'h000000, second_reg};
      end else if (avs_address == `ADCCTL_OFS_PIN_ENABLE) begin
        rdata_next = {28'h0000000, pins_reg};
      end else if (avs_address == `ADCCTL_OFS_RESULT) begin
        rdata_next = result_word;
      end else begin
        rdata_next = 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  assign conv_end = conv_done
                  | (cyc_reg >= 16'(CONV_CYCLES - 1) & conv_clk_en);

  always_comb begin
    state_next       = state_reg;
    busy_next        = busy_reg;
    cyc_next         = cyc_reg;
    start_pulse_next = 1'b0;
    done_pulse_next  = 1'b0;
    result_next      = result_reg;
    case (state_reg)
      CONV_IDLE: begin
        if (start_bit) begin
          state_next = CONV_ARMED;
        end
      end
      CONV_ARMED: begin
        if (!start_bit) begin
          state_next       = CONV_RUN;
          cyc_next         = 16'h0000;
          start_pulse_next = 1'b1;
        end
      end
      CONV_RUN: begin
        if (start_bit) begin
          state_next = CONV_ARMED;
        end else if (conv_end) begin
          state_next      = CONV_IDLE;
          busy_next       = 1'b0;
          done_pulse_next = 1'b1;
          result_next     = conv_result;
        end else if (conv_clk_en) begin
          cyc_next = cyc_reg + 16'h0001;
        end
      end
      default: begin
        state_next = CONV_IDLE;
      end
    endcase
    if (start_bit) begin
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      first_reg       <= `ADCCTL_RST_FIRST;
      second_reg      <= `ADCCTL_RST_SECOND;
      pins_reg        <= `ADCCTL_RST_PINS;
      ack_reg         <= 1'b0;
      rdata_reg       <= 32'h00000000;
      state_reg       <= CONV_IDLE;
      busy_reg        <= 1'b1;
      cyc_reg         <= 16'h0000;
      start_pulse_reg <= 1'b0;
      done_pulse_reg  <= 1'b0;
      result_reg      <= 12'h000;
    end else begin
      first_reg       <= first_next;
      second_reg      <= second_next;
      pins_reg        <= pins_next;
      ack_reg         <= ack_next;
      rdata_reg       <= rdata_next;
      state_reg       <= state_next;
      busy_reg        <= busy_next;
      cyc_reg         <= cyc_next;
      start_pulse_reg <= start_pulse_next;
      done_pulse_reg  <= done_pulse_next;
      result_reg      <= result_next;
    end
  end

  // ----------------------------------------------------------------
  // analog and pin routing
  // ----------------------------------------------------------------
  always_comb begin
    // power control straight from the bit
    analog_ctrl.power_off  = first_reg[`ADCCTL_B_POWER_OFF];
    // converter held in reset while start is high
    analog_ctrl.conv_reset = start_bit;
    analog_ctrl.internal_src_sel = second_reg[`ADCCTL_B_INT_SRC];
    if (second_reg[`ADCCTL_B_INT_SRC]) begin
      analog_ctrl.chan_onehot = 4'h0;
    end else begin
      analog_ctrl.chan_onehot = 4'(5'h01 << first_reg[1:0]);
    end
    // bandgap off unless used or needed by lvr
    analog_ctrl.bandgap_on = second_reg[`ADCCTL_B_BG_EN]
                           | low_voltage_reset_detect;
    analog_ctrl.ref_source_sel = second_reg[`ADCCTL_B_REF_SEL];
    // enable removes digital use and pull-high
    pin_ctrl.analog_pin_enables = pins_reg;
    pin_ctrl.ref_pin_exclusive  = second_reg[`ADCCTL_B_REF_SEL];
  end

  assign conv_start     = start_pulse_reg;
  assign conv_irq_pulse = done_pulse_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_start_fall;
    $fell(start_bit) && state_reg == CONV_ARMED;
  endsequence

  property p_start_launch;
    @(posedge core_clk) disable iff (!rstn)
      s_start_fall |-> ##1 conv_start;
  endproperty
  a_start_launch: assert property (p_start_launch)
    else $error("falling start did not launch a conversion");

  property p_start_busy;
    @(posedge core_clk) disable iff (!rstn)
      start_bit |=> first_reg[`ADCCTL_B_BUSY];
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy low while start high");

  property p_busy_run;
    @(posedge core_clk) disable iff (!rstn)
      conv_start |-> first_reg[`ADCCTL_B_BUSY];
  endproperty
  a_busy_run: assert property (p_busy_run)
    else $error("busy low during conversion");

  property p_end_irq;
    @(posedge core_clk) disable iff (!rstn)
      conv_irq_pulse |-> !first_reg[`ADCCTL_B_BUSY] ##1 !conv_irq_pulse;
  endproperty
  a_end_irq: assert property (p_end_irq)
    else $error("end of conversion did not clear busy");

  property p_holes_zero;
    @(posedge core_clk) disable iff (!rstn)
      first_reg[3:2] == 2'h0 && second_reg[5] == 1'b0
      && second_reg[3] == 1'b0;
  endproperty
  a_holes_zero: assert property (p_holes_zero)
    else $error("unimplemented bit set");

  property p_internal_src;
    @(posedge core_clk) disable iff (!rstn)
      second_reg[`ADCCTL_B_INT_SRC] |-> analog_ctrl.chan_onehot == 4'h0;
  endproperty
  a_internal_src: assert property (p_internal_src)
    else $error("external channel live with internal source");

  property p_chan_sel;
    @(posedge core_clk) disable iff (!rstn)
      !second_reg[`ADCCTL_B_INT_SRC]
        |-> analog_ctrl.chan_onehot[first_reg[1:0]];
  endproperty
  a_chan_sel: assert property (p_chan_sel)
    else $error("wrong external channel routed");

  property p_bg_off;
    @(posedge core_clk) disable iff (!rstn)
      !second_reg[`ADCCTL_B_BG_EN] && !low_voltage_reset_detect
        |-> !analog_ctrl.bandgap_on;
  endproperty
  a_bg_off: assert property (p_bg_off)
    else $error("bandgap left on while unused");

  property p_align;
    @(posedge core_clk) disable iff (!rstn)
      !first_reg[`ADCCTL_B_ALIGN] |-> result_word[3:0] == 4'h0;
  endproperty
  a_align: assert property (p_align)
    else $error("left aligned result has low bits set");

endmodule : adcctl_regs

// [src/adcctl_defs.svh]
/*
  Register offsets, field positions, reset values and timing counts for the
  converter control block. Included by the package and design files.
*/
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADCCTL_OFS_CTRL_FIRST   4'h0
`define ADCCTL_OFS_CTRL_SECOND  4'h4
`define ADCCTL_OFS_PIN_ENABLE   4'h8
`define ADCCTL_OFS_RESULT       4'hC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADCCTL_B_START          7
`define ADCCTL_B_BUSY           6
`define ADCCTL_B_POWER_OFF      5
`define ADCCTL_B_ALIGN          4
`define ADCCTL_B_INT_SRC        7
`define ADCCTL_B_BG_EN          6
`define ADCCTL_B_REF_SEL        4

// ----------------------------------------------------------------
// reset values, masks and the undefined divider code
// ----------------------------------------------------------------
`define ADCCTL_RST_FIRST        8'h60
`define ADCCTL_RST_SECOND       8'h00
`define ADCCTL_RST_PINS         4'hF
`define ADCCTL_MASK_FIRST       8'hF3
`define ADCCTL_MASK_SECOND      8'hD7
`define ADCCTL_CLK_UNDEF        3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADCCTL_CONV_CYCLES      16

`endif

// [src/adcctl_pkg.sv]
/*
  Types for the converter control block.
  Assumes adcctl_defs.svh is on the include path.
*/
`include "adcctl_defs.svh"

package adcctl_pkg;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_ARMED,
    CONV_RUN
  } adcctl_state_t;

  // routing decisions handed to the analog core and pin mux
  typedef struct packed {
    logic       power_off;
    logic       conv_reset;
    logic       internal_src_sel;
    logic [3:0] chan_onehot;
    logic       bandgap_on;
    logic       ref_source_sel;
  } adcctl_analog_t;

  typedef struct packed {
    logic [3:0] analog_pin_enables;
    logic       ref_pin_exclusive;
  } adcctl_pins_t;

endpackage : adcctl_pkg

// [src/adcctl_clkdiv.sv]
/*
  Converter clock divider: enable pulse every 2**sel system clocks.
  Assumes one system clock; code 7 is treated as divide-by-1.
*/
`timescale 1ns/100ps
`include "adcctl_defs.svh"

module adcctl_clkdiv (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] div_sel,
  output logic            conv_clk_en
);
  import adcctl_pkg::*;

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [5:0] limit;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // synchronous counter
  always_comb begin
    if (div_sel == `ADCCTL_CLK_UNDEF) begin
      limit = 6'h00;
    end else begin
      limit = 6'((7'h01 << div_sel) - 7'h01);
    end
    if (cnt_reg >= limit) begin
      cnt_next = 6'h00;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign conv_clk_en = (cnt_reg >= limit);

endmodule : adcctl_clkdiv

// [tb/adcctl_core_model.sv]
/*
  Behavioural analog core facing the control block: starts on conv_start,
  ends with conv_done after a short delay, or never in slow mode.
  Assumes one system clock and the block's reset.
*/
`timescale 1ns/100ps

module adcctl_core_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        conv_start,
  input  wire logic        conv_reset,
  input  wire logic        power_off,
  input  wire logic        slow,
  input  wire logic [11:0] meas,
  output logic      [11:0] conv_result,
  output logic             conv_done
);
  logic [2:0] cnt;
  logic       hold;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt         <= 3'h0;
      hold        <= 1'b0;
      conv_done   <= 1'b0;
      conv_result <= 12'hA5A;
    end else begin
      conv_done <= 1'b0;
      // no result held: toggle so a stale value never matches
      if (!hold)
        conv_result <= ~conv_result;
      if (conv_reset || power_off) begin
        cnt  <= 3'h0;
        hold <= 1'b0;
      end else if (conv_start) begin
        hold        <= 1'b1;
        conv_result <= meas;
        cnt         <= slow ? 3'h0 : 3'h3;
      end else if (cnt == 3'h1) begin
        conv_done <= 1'b1;
        cnt       <= 3'h0;
      end else if (cnt != 3'h0)
        cnt <= cnt - 3'h1;
    end
  end
endmodule : adcctl_core_model

// [tb/tb_adc_control_registers.sv]
/*
  Self-checking bench for the converter control registers.
  Assumes the design files and the core model are compiled first.
*/
`timescale 1ns/100ps

module tb_adc_control_registers;
  import adcctl_pkg::*;
  // plain default settle wait, in system clocks
  localparam int BG_SETTLE = 50;
  // long enough that the core's answer beats the internal count
  localparam int CONV_CYC  = 8;

  logic           core_clk, rstn, avs_read, avs_write;
  logic [3:0]     avs_address, avs_byteenable;
  logic [31:0]    avs_writedata, avs_readdata, rd;
  logic           avs_waitrequest, conv_done, slow, low_voltage_reset_detect;
  logic [11:0]    conv_result, meas, m;
  logic           conv_clk_en, conv_start, conv_irq_pulse, al;
  logic [1:0]     ch;
  logic [7:0]     v;
  adcctl_analog_t analog_ctrl;
  adcctl_pins_t   pin_ctrl;
  int             err_count, cmp_count, starts, p, w;

  adcctl_regs #(.CONV_CYCLES(CONV_CYC)) adcctl_regs_inst (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_result(conv_result), .conv_done(conv_done),
    .low_voltage_reset_detect(low_voltage_reset_detect),
    .analog_ctrl(analog_ctrl), .pin_ctrl(pin_ctrl),
    .conv_clk_en(conv_clk_en), .conv_start(conv_start),
    .conv_irq_pulse(conv_irq_pulse));

  adcctl_core_model adcctl_core_model_inst (
    .core_clk(core_clk), .rstn(rstn), .conv_start(conv_start),
    .conv_reset(analog_ctrl.conv_reset),
    .power_off(analog_ctrl.power_off), .slow(slow), .meas(meas),
    .conv_result(conv_result), .conv_done(conv_done));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(negedge core_clk) if (conv_start === 1'b1) starts++;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic limit(input int n, input int lim, input string w);
    if (n >= lim) begin
      err_count++;
      $display("wrong value %s expected done seen timeout", w);
      end_sim;
    end
  endtask : limit

  // one bus cycle; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    limit(n, 20, "waitrequest");
  endtask : bus

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (conv_irq_pulse !== 1'b1 && n < 500);
    limit(n, 500, "conv_irq_pulse");
  endtask : wait_irq

  // cycles between two divider pulses, capped
  task automatic period(output int q);
    int n;
    n = 0;
    q = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (conv_clk_en !== 1'b1 && n < 200);
    limit(n, 200, "conv_clk_en");
    do begin
      @(negedge core_clk);
      q++;
    end while (conv_clk_en !== 1'b1 && q < 200);
  endtask : period

  initial begin
    rstn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; meas = 12'h0;
    low_voltage_reset_detect = 1'b0; slow = 1'b0; rd = 32'h0;
    err_count = 0; cmp_count = 0; starts = 0;
    void'($urandom(33468));
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    bus(0, 4'h0, 8'h00); chk("first reset", 32'h60, rd);
    bus(0, 4'h4, 8'h00); chk("second reset", 32'h00, rd);
    bus(0, 4'h8, 8'h00); chk("pins reset", 32'h0F, rd);
    bus(0, 4'h2, 8'h00); chk("unmapped", 32'h00, rd);
    chk("pin_ctrl reset", 4'hF, pin_ctrl.analog_pin_enables);
    chk("power reset", 1'b1, analog_ctrl.power_off);
    $display("test reset done");
    // even passes: core answers; odd passes: internal count ends it
    for (int i = 0; i < 4; i++) begin
      al = 1'($urandom);
      ch = 2'($urandom);
      m  = 12'($urandom);
      meas <= m;
      slow <= i[0];
      v = {3'b100, al, 2'b00, ch};
      bus(1, 4'h0, v);
      @(negedge core_clk);
      chk("conv_reset", 1'b1, analog_ctrl.conv_reset);
      chk("chan_onehot", 4'h1 << ch, analog_ctrl.chan_onehot);
      bus(0, 4'h0, 8'h00); chk("busy set", v | 8'h40, rd);
      chk("no early launch", i, starts);
      bus(1, 4'h0, v & 8'h7F);
      wait_irq(w);
      chk("run length", i[0] ? CONV_CYC + 1 : 6, w);
      bus(0, 4'h0, 8'h00); chk("busy clear", v & 8'h7F, rd);
      chk("one launch", i + 1, starts);
      bus(0, 4'hC, 8'h00);
      chk("result", al ? {20'h0, m} : {16'h0, m, 4'h0}, rd);
    end
    bus(1, 4'h0, 8'h4C);
    bus(0, 4'h0, 8'h00); chk("read-only bits", 32'h00, rd);
    $display("test conversion done");
    // code 7 is undefined; this block runs it at the full rate
    for (int c = 0; c < 8; c++) begin
      bus(1, 4'h4, 8'(c));
      period(p);
      period(p);
      chk("divider period", c == 7 ? 1 : 1 << c, p);
    end
    $display("test divider done");
    // enable the bandgap and let it settle before selecting it
    bus(1, 4'h4, 8'h40);
    chk("bandgap on", 1'b1, analog_ctrl.bandgap_on);
    repeat (BG_SETTLE) @(posedge core_clk);
    bus(1, 4'h4, 8'hFF);
    bus(0, 4'h4, 8'h00); chk("second mask", 32'hD7, rd);
    chk("internal src", 1'b1, analog_ctrl.internal_src_sel);
    chk("externals off", 4'h0, analog_ctrl.chan_onehot);
    chk("ref pin", 1'b1, analog_ctrl.ref_source_sel);
    chk("ref exclusive", 1'b1, pin_ctrl.ref_pin_exclusive);
    bus(1, 4'h4, 8'h00);
    @(negedge core_clk);
    chk("bandgap off", 1'b0, analog_ctrl.bandgap_on);
    chk("ref supply", 1'b0, analog_ctrl.ref_source_sel);
    @(posedge core_clk);
    low_voltage_reset_detect <= 1'b1;
    @(negedge core_clk);
    chk("bandgap lvr", 1'b1, analog_ctrl.bandgap_on);
    $display("test source done");
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      bus(1, 4'h8, v);
      bus(0, 4'h8, 8'h00); chk("pins read", v & 8'h0F, rd);
      chk("pin_ctrl", v[3:0], pin_ctrl.analog_pin_enables);
    end
    @(posedge core_clk);
    avs_byteenable <= 4'h0;
    bus(1, 4'h8, ~v);
    avs_byteenable <= 4'hF;
    bus(0, 4'h8, 8'h00); chk("lane off", v & 8'h0F, rd);
    $display("test pins done");
    // park the converter powered down
    bus(1, 4'h0, 8'h20);
    @(negedge core_clk);
    chk("power off", 1'b1, analog_ctrl.power_off);
    $display("test power done");
    // a reset while idle and powered down must bring back the power-on values
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    bus(0, 4'h0, 8'h00); chk("first after reset", 32'h60, rd);
    bus(0, 4'h8, 8'h00); chk("pins after reset", 32'h0F, rd);
    chk("power after reset", 1'b1, analog_ctrl.power_off);
    $display("test reset again done");
    end_sim;
  end
endmodule : tb_adc_control_registers
